//--- include/ptrr_pkg.sv
// constants for the time and rate register block
package ptrr_pkg;
  // ----------------------------------------------------------------
  // register offsets (byte addresses of 16-bit registers)
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_CTRL = 16'h0500;
  localparam logic [15:0] ADDR_SUBPHASE = 16'h0502;
  localparam logic [15:0] ADDR_NS_UP = 16'h0504;
  localparam logic [15:0] ADDR_NS_LO = 16'h0506;
  localparam logic [15:0] ADDR_SEC_UP = 16'h0508;
  localparam logic [15:0] ADDR_SEC_LO = 16'h050a;
  localparam logic [15:0] ADDR_RATE_UP = 16'h050c;
  localparam logic [15:0] ADDR_RATE_LO = 16'h050e;
  localparam logic [15:0] ADDR_DUR_UP = 16'h0510;
  localparam logic [15:0] ADDR_DUR_LO = 16'h0512;
  // ----------------------------------------------------------------
  // control register bits
  // ----------------------------------------------------------------
  localparam int CTL_RESET = 0;
  localparam int CTL_ENABLE = 1;
  localparam int CTL_CONT = 2;
  localparam int CTL_LOAD = 3;
  localparam int CTL_READ = 4;
  localparam int CTL_STEP_DIR = 5;
  localparam int CTL_STEP = 6;
  // ----------------------------------------------------------------
  // rate upper word bits and phase field
  // ----------------------------------------------------------------
  localparam int RATE_SIGN_BIT = 15;
  localparam int RATE_TEMP_BIT = 14;
  localparam int RATE_HI_W = 14;
  localparam int RATE_W = 30;
  localparam int PHASE_W = 3;
  localparam logic [2:0] PHASE_LAST = 3'h4;
  localparam logic [15:0] RST_WORD = 16'h0000;
  // ----------------------------------------------------------------
  // timing: 25 MHz tick from 100 MHz, 8 ns phase slice, 40 ns tick
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 100000000;
  localparam int TICK_HZ = 25000000;
  localparam int TICK_DIV = CLK_HZ / TICK_HZ;
  localparam logic [31:0] TICK_NS = 32'h0000_0028;
  localparam logic [31:0] NS_PER_SEC = 32'h3b9a_ca00;
endpackage

//--- design/ptrr_tick_gen.sv
// divider that makes the one-cycle 25 MHz tick strobe
`timescale 1ns/1ps
module ptrr_tick_gen #(
  parameter int DIV = ptrr_pkg::TICK_DIV
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  output logic tick_o
);
  localparam int CW = $clog2(DIV) + 1;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic next_tick;

  always_comb begin
    if (cnt == CW'(DIV - 1)) begin
      next_cnt = '0;
      next_tick = 1'b1;
    end else begin
      next_cnt = cnt + CW'(1);
      next_tick = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cnt <= '0;
      tick_o <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick_o <= next_tick;
    end
  end
endmodule

//--- design/ptrr_dur_counter.sv
// temporary adjustment duration down-counter
`timescale 1ns/1ps
module ptrr_dur_counter #(
  parameter int W = 32
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic stop_i,
  input wire logic tick_i,
  input wire logic [W-1:0] count_i,
  output logic active_o,
  output logic done_o
);
  logic [W-1:0] remain;
  logic [W-1:0] next_remain;
  logic next_active;
  logic next_done;

  always_comb begin
    next_remain = remain;
    next_active = active_o;
    next_done = 1'b0;
    if (stop_i) begin
      next_active = 1'b0;
    end else if (start_i) begin
      next_remain = count_i;
      next_active = (count_i != '0);
      next_done = (count_i == '0);
    end else if (active_o && tick_i) begin
      next_remain = remain - W'(1);
      if (remain == W'(1)) begin
        next_active = 1'b0;
        next_done = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      remain <= '0;
      active_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      remain <= next_remain;
      active_o <= next_active;
      done_o <= next_done;
    end
  end
endmodule

//--- design/ptrr_top.sv
// time and rate register block of the precision time clock
`timescale 1ns/1ps
module ptrr_top #(
  parameter int RATE_W = ptrr_pkg::RATE_W,
  parameter int DUR_W = 32
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  output logic reg_rvalid_o,
  output logic [31:0] time_ns_o,
  output logic [31:0] time_sec_o,
  output logic [2:0] time_phase_o
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [6:0] ctrl;
  logic [2:0] sh_phase;
  logic [31:0] sh_ns;
  logic [31:0] sh_sec;
  logic rate_sign_select;
  logic temp_en;
  logic [RATE_W-1:0] subnanosecond_rate_value;
  logic [DUR_W-1:0] dur;
  logic [31:0] rt_ns;
  logic [31:0] rt_sec;
  logic [2:0] rt_phase;
  logic [RATE_W-1:0] rt_frac;
  logic [6:0] next_ctrl;
  logic [2:0] next_sh_phase;
  logic [31:0] next_sh_ns;
  logic [31:0] next_sh_sec;
  logic next_rate_sign_select;
  logic next_temp_en;
  logic [RATE_W-1:0] next_subnanosecond_rate_value;
  logic [DUR_W-1:0] next_dur;
  logic [31:0] next_rt_ns;
  logic [31:0] next_rt_sec;
  logic [2:0] next_rt_phase;
  logic [RATE_W-1:0] next_rt_frac;
  logic [15:0] next_rdata;
  logic tick;
  logic dur_active;
  logic dur_done;
  logic temp_start;
  logic temp_stop;
  logic wr_rate_up;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  ptrr_tick_gen #(
    .DIV(ptrr_pkg::TICK_DIV)
  ) u_tick (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .tick_o(tick)
  );

  assign wr_rate_up = reg_wr_i && (reg_addr_i == ptrr_pkg::ADDR_RATE_UP);
  assign temp_start = wr_rate_up && reg_wdata_i[ptrr_pkg::RATE_TEMP_BIT];
  assign temp_stop = wr_rate_up && !reg_wdata_i[ptrr_pkg::RATE_TEMP_BIT];

  ptrr_dur_counter #(
    .W(DUR_W)
  ) u_dur (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .start_i(temp_start),
    .stop_i(temp_stop),
    .tick_i(tick),
    .count_i(dur),
    .active_o(dur_active),
    .done_o(dur_done)
  );

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  always_comb begin
    next_ctrl = ctrl;
    next_sh_phase = sh_phase;
    next_sh_ns = sh_ns;
    next_sh_sec = sh_sec;
    next_rate_sign_select = rate_sign_select;
    next_temp_en = temp_en;
    next_subnanosecond_rate_value = subnanosecond_rate_value;
    next_dur = dur;
    // command bits are self-clearing after one cycle
    next_ctrl[ptrr_pkg::CTL_RESET] = 1'b0;
    next_ctrl[ptrr_pkg::CTL_LOAD] = 1'b0;
    next_ctrl[ptrr_pkg::CTL_READ] = 1'b0;
    next_ctrl[ptrr_pkg::CTL_STEP] = 1'b0;
    if (dur_done) begin
      next_temp_en = 1'b0;
    end
    if (ctrl[ptrr_pkg::CTL_READ]) begin
      next_sh_phase = rt_phase;
      next_sh_ns = rt_ns;
      next_sh_sec = rt_sec;
    end
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        ptrr_pkg::ADDR_CTRL: begin
          next_ctrl = reg_wdata_i[6:0];
        end
        ptrr_pkg::ADDR_SUBPHASE: begin
          next_sh_phase = reg_wdata_i[ptrr_pkg::PHASE_W-1:0];
        end
        ptrr_pkg::ADDR_NS_UP: begin
          next_sh_ns[31:16] = reg_wdata_i;
        end
        ptrr_pkg::ADDR_NS_LO: begin
          next_sh_ns[15:0] = reg_wdata_i;
        end
        ptrr_pkg::ADDR_SEC_UP: begin
          next_sh_sec[31:16] = reg_wdata_i;
        end
        ptrr_pkg::ADDR_SEC_LO: begin
          next_sh_sec[15:0] = reg_wdata_i;
        end
        ptrr_pkg::ADDR_RATE_UP: begin
          next_rate_sign_select = reg_wdata_i[ptrr_pkg::RATE_SIGN_BIT];
          next_temp_en = reg_wdata_i[ptrr_pkg::RATE_TEMP_BIT];
          next_subnanosecond_rate_value[RATE_W-1:16] = reg_wdata_i[RATE_W-17:0];
        end
        ptrr_pkg::ADDR_RATE_LO: begin
          next_subnanosecond_rate_value[15:0] = reg_wdata_i;
        end
        ptrr_pkg::ADDR_DUR_UP: begin
          next_dur[31:16] = reg_wdata_i;
        end
        ptrr_pkg::ADDR_DUR_LO: begin
          next_dur[15:0] = reg_wdata_i;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ctrl <= '0;
      sh_phase <= '0;
      sh_ns <= '0;
      sh_sec <= '0;
      rate_sign_select <= 1'b0;
      temp_en <= 1'b0;
      subnanosecond_rate_value <= '0;
      dur <= '0;
    end else begin
      ctrl <= next_ctrl;
      sh_phase <= next_sh_phase;
      sh_ns <= next_sh_ns;
      sh_sec <= next_sh_sec;
      rate_sign_select <= next_rate_sign_select;
      temp_en <= next_temp_en;
      subnanosecond_rate_value <= next_subnanosecond_rate_value;
      dur <= next_dur;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = ptrr_pkg::RST_WORD;
    unique case (reg_addr_i)
      ptrr_pkg::ADDR_CTRL: next_rdata = {9'h000, ctrl};
      ptrr_pkg::ADDR_SUBPHASE: next_rdata = {13'h0000, sh_phase};
      ptrr_pkg::ADDR_NS_UP: next_rdata = sh_ns[31:16];
      ptrr_pkg::ADDR_NS_LO: next_rdata = sh_ns[15:0];
      ptrr_pkg::ADDR_SEC_UP: next_rdata = sh_sec[31:16];
      ptrr_pkg::ADDR_SEC_LO: next_rdata = sh_sec[15:0];
      ptrr_pkg::ADDR_RATE_UP: begin
        next_rdata = {rate_sign_select, temp_en, subnanosecond_rate_value[RATE_W-1:16]};
      end
      ptrr_pkg::ADDR_RATE_LO: next_rdata = subnanosecond_rate_value[15:0];
      ptrr_pkg::ADDR_DUR_UP: next_rdata = dur[31:16];
      ptrr_pkg::ADDR_DUR_LO: next_rdata = dur[15:0];
      default: next_rdata = ptrr_pkg::RST_WORD;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= ptrr_pkg::RST_WORD;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rdata_o <= reg_rd_i ? next_rdata : ptrr_pkg::RST_WORD;
      reg_rvalid_o <= reg_rd_i;
    end
  end

  // ----------------------------------------------------------------
  // live clock
  // ----------------------------------------------------------------
  logic rate_on;
  logic [RATE_W:0] frac_sum;
  logic [31:0] ns_adj;
  logic [31:0] ns_tmp;
  logic [32:0] ns_wide;

  always_comb begin
    next_rt_ns = rt_ns;
    next_rt_sec = rt_sec;
    next_rt_phase = rt_phase;
    next_rt_frac = rt_frac;
    rate_on = ctrl[ptrr_pkg::CTL_CONT] || (temp_en && dur_active);
    frac_sum = '0;
    ns_adj = '0;
    ns_tmp = rt_ns;
    ns_wide = '0;
    if (ctrl[ptrr_pkg::CTL_ENABLE] && tick) begin
      ns_tmp = rt_ns + ptrr_pkg::TICK_NS;
      if (rate_on && rate_sign_select) begin
        frac_sum = {1'b0, rt_frac} + {1'b0, subnanosecond_rate_value};
        ns_tmp = ns_tmp + 32'(frac_sum[RATE_W]);
      end else if (rate_on) begin
        frac_sum = {1'b0, rt_frac} - {1'b0, subnanosecond_rate_value};
        ns_tmp = ns_tmp - 32'(frac_sum[RATE_W]);
      end else begin
        frac_sum = {1'b0, rt_frac};
      end
      next_rt_frac = frac_sum[RATE_W-1:0];
      if (ns_tmp >= ptrr_pkg::NS_PER_SEC) begin
        next_rt_ns = ns_tmp - ptrr_pkg::NS_PER_SEC;
        next_rt_sec = rt_sec + 32'h0000_0001;
      end else begin
        next_rt_ns = ns_tmp;
      end
    end
    // step by nanosecond register
    // step builds on this cycle's tick so neither is lost
    if (ctrl[ptrr_pkg::CTL_STEP]) begin
      if (ctrl[ptrr_pkg::CTL_STEP_DIR]) begin
        ns_wide = {1'b0, next_rt_ns} + {1'b0, sh_ns};
        if (ns_wide >= {1'b0, ptrr_pkg::NS_PER_SEC}) begin
          ns_adj = 32'(ns_wide - {1'b0, ptrr_pkg::NS_PER_SEC});
          next_rt_sec = next_rt_sec + 32'h0000_0001;
        end else begin
          ns_adj = ns_wide[31:0];
        end
      end else if (next_rt_ns >= sh_ns) begin
        ns_adj = next_rt_ns - sh_ns;
      end else begin
        ns_adj = next_rt_ns + ptrr_pkg::NS_PER_SEC - sh_ns;
        next_rt_sec = next_rt_sec - 32'h0000_0001;
      end
      next_rt_ns = ns_adj;
    end
    if (ctrl[ptrr_pkg::CTL_LOAD]) begin
      next_rt_ns = sh_ns;
      next_rt_sec = sh_sec;
      next_rt_phase = (sh_phase > ptrr_pkg::PHASE_LAST) ? ptrr_pkg::PHASE_LAST : sh_phase;
    end
    if (ctrl[ptrr_pkg::CTL_RESET]) begin
      next_rt_ns = '0;
      next_rt_sec = '0;
      next_rt_phase = '0;
      next_rt_frac = '0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rt_ns <= '0;
      rt_sec <= '0;
      rt_phase <= '0;
      rt_frac <= '0;
      time_ns_o <= '0;
      time_sec_o <= '0;
      time_phase_o <= '0;
    end else begin
      rt_ns <= next_rt_ns;
      rt_sec <= next_rt_sec;
      rt_phase <= next_rt_phase;
      rt_frac <= next_rt_frac;
      time_ns_o <= next_rt_ns;
      time_sec_o <= next_rt_sec;
      time_phase_o <= next_rt_phase;
    end
  end
endmodule

//--- sim/ptrr_props.sv
// concurrent checks on the time and rate register block ports
`timescale 1ns/1ps
module ptrr_props (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic [31:0] time_ns_o,
  input wire logic [31:0] time_sec_o,
  input wire logic [2:0] time_phase_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  property p_rv;
    reg_rd_i |=> reg_rvalid_o;
  endproperty
  a_rv: assert property (p_rv) else $error("read not answered");
  property p_norv;
    !reg_rd_i |=> !reg_rvalid_o && reg_rdata_o == 16'h0000;
  endproperty
  a_norv: assert property (p_norv) else $error("answer without read");
  property p_phase;
    time_phase_o <= ptrr_pkg::PHASE_LAST;
  endproperty
  a_phase: assert property (p_phase) else $error("phase code out of range");
  property p_sub;
    reg_rd_i && reg_addr_i == ptrr_pkg::ADDR_SUBPHASE |=>
      reg_rdata_o[15:3] == 13'h0000 && reg_rdata_o[2:0] <= ptrr_pkg::PHASE_LAST;
  endproperty
  a_sub: assert property (p_sub) else $error("phase read wrong");
  property p_hold;
    !(reg_wr_i && reg_addr_i == ptrr_pkg::ADDR_CTRL) |-> ##2 $stable(time_phase_o);
  endproperty
  a_hold: assert property (p_hold) else $error("phase moved without command");
  property p_wrrd;
    logic [15:0] a;
    logic [15:0] v;
    (reg_wr_i && reg_addr_i inside {16'h0504, 16'h0506, 16'h0508, 16'h050a, 16'h050e},
      a = reg_addr_i, v = reg_wdata_i) ##1 !reg_wr_i
      ##1 (reg_rd_i && !reg_wr_i && reg_addr_i == a) |=> reg_rdata_o == v;
  endproperty
  a_wrrd: assert property (p_wrrd) else $error("register lost its value");
  property p_unmap;
    reg_rd_i && reg_addr_i > ptrr_pkg::ADDR_DUR_LO |=> reg_rdata_o == 16'h0000;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_rst;
    disable iff (1'b0)
    rst_i |=> time_ns_o == 32'h0 && time_sec_o == 32'h0 && time_phase_o == 3'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("time not cleared by reset");
endmodule

//--- sim/tb.sv
// self-checking bench for the time and rate register block
`timescale 1ns/1ps
module tb;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [15:0] reg_addr_i = 16'h0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic [15:0] reg_rdata_o;
  logic reg_rvalid_o;
  logic [31:0] time_ns_o;
  logic [31:0] time_sec_o;
  logic [2:0] time_phase_o;
  logic [31:0] t0;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  // ----------------------------------------------------------------
  // rows: address, write data, expected read back
  // ----------------------------------------------------------------
  localparam logic [47:0] ROWS [8] = '{48'h0502_fffb_0003, 48'h0504_a5c3_a5c3,
    48'h0506_1234_1234, 48'h0508_00ff_00ff, 48'h050a_beef_beef, 48'h050c_b123_b123,
    48'h050e_5a5a_5a5a, 48'h0600_ffff_0000};
  // rate word, control word, expected ns gain over ten ticks
  localparam logic [47:0] RATES [3] = '{48'h0000_0002_0190, 48'ha000_0006_0195,
    48'h2000_0006_018b};
  ptrr_top DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .time_ns_o(time_ns_o),
    .time_sec_o(time_sec_o), .time_phase_o(time_phase_o));
  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk($sformatf("rvalid %h", a), 32'h1, {31'h0, reg_rvalid_o});
    chk($sformatf("rdata %h", a), {16'h0, e}, {16'h0, reg_rdata_o});
  endtask
  task automatic wait3();
    repeat (3) @(posedge ref_clk_i);
    #1;
  endtask
  // ten ticks of 40 ns fall in any 40 cycle span
  task automatic measure(input logic [31:0] d);
    #1;
    t0 = time_ns_o;
    repeat (40) @(posedge ref_clk_i);
    #1;
    chk("ns gain", t0 + d, time_ns_o);
  endtask
  task automatic results();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      results();
    end
  end
  initial begin
    repeat (5) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      rd(16'h0502 + 16'(2 * i), 16'h0000);
    end
    for (int i = 0; i < 8; i++) begin
      wr(ROWS[i][47:32], ROWS[i][31:16]);
      rd(ROWS[i][47:32], ROWS[i][15:0]);
    end
    wr(16'h0504, 16'h0000);
    wr(16'h0506, 16'h0100);
    wr(16'h0508, 16'h0000);
    wr(16'h050a, 16'h0005);
    wr(16'h0502, 16'h0002);
    wr(16'h0500, 16'h0008);
    wait3();
    chk("load ns", 32'h0000_0100, time_ns_o);
    chk("load sec", 32'h0000_0005, time_sec_o);
    chk("load phase", 32'h2, {29'h0, time_phase_o});
    wr(16'h0506, 16'h0077);
    wr(16'h0502, 16'h0000);
    wr(16'h0500, 16'h0010);
    wait3();
    rd(16'h0506, 16'h0100);
    rd(16'h0502, 16'h0002);
    wr(16'h0506, 16'h0064);
    wr(16'h0500, 16'h0060);
    wait3();
    chk("step add", 32'h0000_0164, time_ns_o);
    wr(16'h0500, 16'h0040);
    wait3();
    chk("step sub", 32'h0000_0100, time_ns_o);
    wr(16'h050e, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      wr(16'h050c, RATES[i][47:32]);
      wr(16'h0500, RATES[i][31:16]);
      repeat (8) @(posedge ref_clk_i);
      measure({16'h0, RATES[i][15:0]});
    end
    wr(16'h0500, 16'h0002);
    wr(16'h0510, 16'h0000);
    wr(16'h0512, 16'h0004);
    rd(16'h0512, 16'h0004);
    // sample before the start so the first rate tick lands inside the span
    #1;
    t0 = time_ns_o;
    wr(16'h050c, 16'he000);
    repeat (38) @(posedge ref_clk_i);
    #1;
    chk("temp gain", t0 + 32'h0000_0192, time_ns_o);
    rd(16'h050c, 16'ha000);
    wr(16'h0512, 16'h1000);
    wr(16'h050c, 16'he000);
    repeat (8) @(posedge ref_clk_i);
    wr(16'h050c, 16'ha000);
    repeat (4) @(posedge ref_clk_i);
    measure(32'h0000_0190);
    wr(16'h0500, 16'h0001);
    wait3();
    chk("clear ns", 32'h0, time_ns_o);
    chk("clear sec", 32'h0, time_sec_o);
    results();
  end
endmodule
bind ptrr_top ptrr_props u_props (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
  .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
  .time_ns_o(time_ns_o), .time_sec_o(time_sec_o), .time_phase_o(time_phase_o));
